// ---- hw/sstm_defines.vh ----
`ifndef SSTM_DEFINES_VH
`define SSTM_DEFINES_VH

// ************************************************************
// Status byte fields and values
// ************************************************************
`define SSTM_STAT_GOOD        8'h00
`define SSTM_STAT_CHECK_BIT   1
`define SSTM_STAT_BUSY_BIT    3
`define SSTM_STAT_INTER_BIT   4

// ************************************************************
// Message codes
// ************************************************************
`define SSTM_MSG_CMD_DONE     8'h00
`define SSTM_MSG_SAVE_PTR     8'h02
`define SSTM_MSG_RESTORE_PTR  8'h03
`define SSTM_MSG_DISCONNECT   8'h04
`define SSTM_MSG_ABORT        8'h06
`define SSTM_MSG_REJECT       8'h07
`define SSTM_MSG_NOP          8'h08
`define SSTM_MSG_PARITY_ERR   8'h09
`define SSTM_MSG_LINK_DONE    8'h0a
`define SSTM_MSG_LINK_FLAG    8'h0b
`define SSTM_MSG_DEV_RESET    8'h0c
`define SSTM_IDENT_BIT        7
`define SSTM_IDENT_DISCONNECT_ALLOWED_BIT_BIT   6

// ************************************************************
// Retry limits and bus timing
// ************************************************************
`define SSTM_PARITY_TRIES     2'd3
// 400 ns phase setup at a 50 ns clock, rounded up to whole cycles
`define SSTM_SETUP_CYC        4'd8

`endif

// ---- hw/sstm_sync2.v ----
`timescale 1ns/1ps
// ************************************************************
// Two-stage synchroniser for one bus line
// ************************************************************
module sstm_sync2 (
  // Clock and reset
  input  wire mclk,
  input  wire rst,
  // Data
  input  wire din,
  output wire dout
);
  reg meta_ff;   // First stage, read only by second
  reg sync_ff;   // Second stage, safe to use

  // Plain double flop, constant reset
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;
endmodule // sstm_sync2

// ---- hw/sstm_target.v ----
`timescale 1ns/1ps
`include "sstm_defines.vh"
module sstm_target (
  // Clock and reset
  input  wire       mclk,
  input  wire       rst,
  // Bus lines from initiator (asynchronous)
  input  wire       bus_ack,
  input  wire       bus_atn,
  input  wire       bus_rst,
  input  wire [7:0] bus_db_in,
  input  wire       bus_dbp_ok,
  // Bus lines driven by target
  output reg        bus_req,
  output reg        bus_bsy,
  output reg        bus_cd,
  output reg        bus_io,
  output reg        bus_msg,
  output reg  [7:0] bus_db_out,
  output reg        bus_db_oe,
  // Engine side
  input  wire       sel_done,
  input  wire       cmd_done,
  input  wire       comm_fail,
  input  wire       check_condition_flag,
  input  wire       stat_busy,
  input  wire       stat_inter,
  input  wire       link_cmd,
  input  wire       link_flag,
  input  wire       parity_enable,
  input  wire       data_parity_err,
  input  wire       send_save_ptr,
  input  wire       want_disconnect,
  input  wire       resel_won,
  output reg        disconnect_allowed_bit,
  output reg        identified,
  output reg  [2:0] ident_lun,
  output reg        abort_cmd,
  output reg        dev_reset,
  output reg        bus_free_req,
  output reg        resel_req,
  output reg        rst_clear,
  output reg        busy
);
  // ************************************************************
  // State codes and timing
  // ************************************************************
  localparam [3:0] ST_FREE   = 4'h0;  // Bus free, idle
  localparam [3:0] ST_SETUP  = 4'h1;  // Phase lines settling
  localparam [3:0] ST_REQ    = 4'h2;  // REQ high, wait ACK
  localparam [3:0] ST_ACKLOW = 4'h3;  // REQ low, wait ACK low
  localparam [3:0] ST_DECIDE = 4'h4;  // Choose next step
  localparam [3:0] ST_DISCONNECT_ALLOWED_BIT   = 4'h5;  // Disconnected, executing
  localparam [3:0] ST_CONN   = 4'h6;  // Connected, executing
  localparam [1:0] PH_STAT   = 2'd0;
  localparam [1:0] PH_MIN    = 2'd1;
  localparam [1:0] PH_MOUT   = 2'd2;
  localparam [3:0] SETUP_CYC = `SSTM_SETUP_CYC;

  // ************************************************************
  // Synchronised bus inputs
  // ************************************************************
  wire ack_s;   // ACK after two flops
  wire atn_s;   // ATN after two flops
  wire rst_s;   // Bus reset after two flops
  wire par_s;   // Parity good after two flops
  reg  [7:0] db_m_ff;  // Data bus first stage
  reg  [7:0] db_s_ff;  // Data bus second stage

  sstm_sync2 u_ack (.mclk(mclk), .rst(rst), .din(bus_ack),    .dout(ack_s));
  sstm_sync2 u_atn (.mclk(mclk), .rst(rst), .din(bus_atn),    .dout(atn_s));
  sstm_sync2 u_rst (.mclk(mclk), .rst(rst), .din(bus_rst),    .dout(rst_s));
  sstm_sync2 u_par (.mclk(mclk), .rst(rst), .din(bus_dbp_ok), .dout(par_s));

  // Data sampled twice; stable by ACK since initiator sets it first
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      db_m_ff <= 8'h00;
      db_s_ff <= 8'h00;
    end else begin
      db_m_ff <= bus_db_in;
      db_s_ff <= db_m_ff;
    end
  end

  // ************************************************************
  // Control state
  // ************************************************************
  reg [3:0] st_ff;        // Sequencer state
  reg [1:0] ph_ff;        // Phase of current byte
  reg [3:0] cnt_ff;       // Setup counter
  reg [1:0] tries_ff;     // Parity failures in a row
  reg       stat_sent_ff; // Status already sent
  reg       need_rej_ff;  // Reject owed to initiator
  reg       done_ff;      // Command complete owed
  reg       disconnect_allowed_bit_go_ff;   // Disconnect in flight
  reg [7:0] last_ff;      // Last byte received

  // Status byte built from engine flags, other bits zero
  wire [7:0] stat_byte = ({7'h00, check_condition_flag} << `SSTM_STAT_CHECK_BIT)
                       | ({7'h00, stat_busy}            << `SSTM_STAT_BUSY_BIT)
                       | ({7'h00, stat_inter}           << `SSTM_STAT_INTER_BIT);

  // Closing message picks linked or plain completion
  wire [7:0] done_code = link_cmd ? (link_flag ? `SSTM_MSG_LINK_FLAG : `SSTM_MSG_LINK_DONE)
                                  : `SSTM_MSG_CMD_DONE;

  // Received message classes
  // Decoded from the byte latched at ACK, not the live bus
  wire is_ident = last_ff[`SSTM_IDENT_BIT];
  wire known    = is_ident || last_ff == `SSTM_MSG_ABORT || last_ff == `SSTM_MSG_REJECT
                || last_ff == `SSTM_MSG_NOP || last_ff == `SSTM_MSG_PARITY_ERR
                || last_ff == `SSTM_MSG_DEV_RESET;

  // Message-out byte that closes the connection: abort, device reset, parity limit
  wire par_bad  = parity_enable && !par_s;
  wire mout_end = par_bad ? (tries_ff == `SSTM_PARITY_TRIES - 2'd1)
                          : (last_ff == `SSTM_MSG_ABORT || last_ff == `SSTM_MSG_DEV_RESET);
  // A reject never closes the connection, even with completion owed
  wire fin_ok   = (bus_db_out != `SSTM_MSG_REJECT);

  // Drive phase lines per phase
  task set_phase;
    input [1:0] ph;
    begin
      bus_cd  <= 1'b1;
      bus_io  <= (ph != PH_MOUT);
      bus_msg <= (ph != PH_STAT);
      ph_ff   <= ph;
      cnt_ff  <= 4'h0;
      st_ff   <= ST_SETUP;
    end
  endtask

  // Load an outgoing byte and start its handshake
  task send_byte;
    input [1:0] ph;
    input [7:0] b;
    begin
      bus_db_out <= b;
      set_phase(ph);
    end
  endtask

  // ************************************************************
  // Main sequencer
  // ************************************************************
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_ff <= ST_FREE;
      ph_ff <= PH_STAT;
      cnt_ff <= 4'h0;
      tries_ff <= 2'd0;
      stat_sent_ff <= 1'b0;
      need_rej_ff <= 1'b0;
      done_ff <= 1'b0;
      disconnect_allowed_bit_go_ff <= 1'b0;
      last_ff <= 8'h00;
      bus_req <= 1'b0;
      bus_bsy <= 1'b0;
      bus_cd <= 1'b0;
      bus_io <= 1'b0;
      bus_msg <= 1'b0;
      bus_db_out <= 8'h00;
      bus_db_oe <= 1'b0;
      disconnect_allowed_bit <= 1'b0;
      identified <= 1'b0;
      ident_lun <= 3'd0;
      abort_cmd <= 1'b0;
      dev_reset <= 1'b0;
      bus_free_req <= 1'b0;
      resel_req <= 1'b0;
      rst_clear <= 1'b0;
      busy <= 1'b0;
    end else begin
      // One-cycle pulses default low
      abort_cmd <= 1'b0;
      dev_reset <= 1'b0;
      bus_free_req <= 1'b0;
      rst_clear <= 1'b0;
      if (rst_s) begin
        // Bus reset overrides every phase at once
        st_ff <= ST_FREE;
        bus_req <= 1'b0;
        bus_bsy <= 1'b0;
        bus_cd <= 1'b0;
        bus_io <= 1'b0;
        bus_msg <= 1'b0;
        bus_db_oe <= 1'b0;
        need_rej_ff <= 1'b0;
        done_ff <= 1'b0;
        stat_sent_ff <= 1'b0;
        disconnect_allowed_bit_go_ff <= 1'b0;
        tries_ff <= 2'd0;
        identified <= 1'b0;
        disconnect_allowed_bit <= 1'b0;
        resel_req <= 1'b0;
        busy <= 1'b0;
        rst_clear <= 1'b1;        // Engine drops commands, reservations, buffer
      end else begin
        case (st_ff)
          ST_FREE: begin
            if (sel_done) begin
              bus_bsy <= 1'b1;
              busy <= 1'b1;
              tries_ff <= 2'd0;
              stat_sent_ff <= 1'b0;
              identified <= 1'b0;             // A new nexus needs its own identify
              disconnect_allowed_bit <= 1'b0;
              if (atn_s) begin
                set_phase(PH_MOUT);  // Message-out right after selection
              end else begin
                st_ff <= ST_CONN;
              end
            end
          end
          ST_SETUP: begin
            // Hold phase lines settled before REQ; one byte per REQ
            bus_db_oe <= (ph_ff != PH_MOUT);
            if (cnt_ff == SETUP_CYC) begin
              bus_req <= 1'b1;
              st_ff <= ST_REQ;
            end else begin
              cnt_ff <= cnt_ff + 4'h1;
            end
          end
          ST_REQ: begin
            if (ack_s) begin
              bus_req <= 1'b0;
              last_ff <= db_s_ff;
              st_ff <= ST_ACKLOW;
            end
          end
          ST_ACKLOW: begin
            if (!ack_s) begin
              st_ff <= ST_DECIDE;
              if (ph_ff == PH_STAT) begin
                stat_sent_ff <= 1'b1;
                done_ff <= 1'b1;      // Completion follows status
              end else if (ph_ff == PH_MOUT) begin
                if (parity_enable && !par_s) begin
                  // Retry collection, abort at limit
                  if (tries_ff == `SSTM_PARITY_TRIES - 2'd1) begin
                    tries_ff <= 2'd0;
                    abort_cmd <= 1'b1;
                    st_ff <= ST_FREE;
                    bus_free_req <= 1'b1;
                  end else begin
                    tries_ff <= tries_ff + 2'd1;
                    set_phase(PH_MOUT);
                  end
                end else begin
                  tries_ff <= 2'd0;
                  if (is_ident) begin
                    identified <= 1'b1;
                    ident_lun <= last_ff[2:0];
                    disconnect_allowed_bit <= last_ff[`SSTM_IDENT_DISCONNECT_ALLOWED_BIT_BIT];
                  end else if (last_ff == `SSTM_MSG_ABORT) begin
                    abort_cmd <= 1'b1;
                    st_ff <= ST_FREE;
                    bus_free_req <= 1'b1;
                  end else if (last_ff == `SSTM_MSG_DEV_RESET) begin
                    dev_reset <= 1'b1;
                    st_ff <= ST_FREE;
                    bus_free_req <= 1'b1;
                  end else if (!known) begin
                    need_rej_ff <= 1'b1;  // Unknown or multi-byte lead
                  end
                end
              end else if (disconnect_allowed_bit_go_ff && fin_ok) begin
                disconnect_allowed_bit_go_ff <= 1'b0;
                st_ff <= ST_DISCONNECT_ALLOWED_BIT;       // Stay busy after disconnect sent
              end else if (done_ff && fin_ok) begin
                done_ff <= 1'b0;
                st_ff <= ST_FREE;       // Bus free after completion
                busy <= 1'b0;
              end
              // Free the bus after completion, disconnect or a closing message-out
              if ((ph_ff == PH_MIN && fin_ok && (disconnect_allowed_bit_go_ff || done_ff)) || (ph_ff == PH_MOUT && mout_end)) begin
                busy <= ph_ff == PH_MIN && disconnect_allowed_bit_go_ff;  // Still busy only while disconnected
                bus_bsy <= 1'b0;
                bus_cd <= 1'b0;
                bus_io <= 1'b0;
                bus_msg <= 1'b0;
                bus_db_oe <= 1'b0;
                bus_free_req <= 1'b1;
              end
            end
          end
          ST_DECIDE: begin
            bus_db_oe <= 1'b0;
            if (need_rej_ff) begin
              need_rej_ff <= 1'b0;
              send_byte(PH_MIN, `SSTM_MSG_REJECT);
            end else if (ph_ff == PH_MIN && bus_db_out == `SSTM_MSG_REJECT) begin
              set_phase(PH_MOUT);                   // Back to message-out
            end else if (atn_s) begin
              set_phase(PH_MOUT);                   // Collect pending message
            end else if (done_ff) begin
              send_byte(PH_MIN, done_code);
            end else begin
              st_ff <= ST_CONN;
            end
          end
          ST_CONN: begin
            if (atn_s) begin
              set_phase(PH_MOUT);
            end else if (data_parity_err) begin
              send_byte(PH_MIN, `SSTM_MSG_RESTORE_PTR); // Engine retries after
            end else if (send_save_ptr) begin
              send_byte(PH_MIN, `SSTM_MSG_SAVE_PTR);
            end else if (want_disconnect && disconnect_allowed_bit) begin
              disconnect_allowed_bit_go_ff <= 1'b1;
              send_byte(PH_MIN, `SSTM_MSG_DISCONNECT);
            end else if (cmd_done || comm_fail) begin
              send_byte(PH_STAT, stat_byte);            // Single status byte
            end
          end
          ST_DISCONNECT_ALLOWED_BIT: begin
            // Keep executing off-bus; reselect when done
            if (cmd_done || comm_fail) begin
              resel_req <= 1'b1;
            end
            if (resel_req && resel_won) begin
              resel_req <= 1'b0;
              bus_bsy <= 1'b1;
              send_byte(PH_STAT, stat_byte);
            end
          end
          default: st_ff <= ST_FREE;
        endcase
      end
    end
  end
endmodule // sstm_target

// ---- testbench/sstm_init_model.sv ----
`timescale 1ns/1ps
// ****
// Initiator model
// ****
module sstm_init_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Lines from target
  input  wire logic       bus_req,
  input  wire logic       bus_cd,
  input  wire logic       bus_io,
  input  wire logic       bus_msg,
  input  wire logic [7:0] bus_db_out,
  // Lines to target
  output logic            bus_ack,
  output logic [7:0]      bus_db_in,
  output logic            bus_dbp_ok,
  // Bench control and log
  input  wire logic [7:0] tx_byte,
  input  wire logic       par_ok,
  input  wire logic [3:0] ack_dly,
  output logic [7:0]      rx_byte,
  output logic [2:0]      rx_ph,
  output logic [7:0]      rx_cnt
);
  logic [3:0] wait_ff; // Slow answer count
  // Released lines show the inverse of the last byte
  assign bus_db_in  = bus_io ? ~rx_byte : tx_byte;
  assign bus_dbp_ok = bus_io ? 1'b0 : par_ok;
  // One byte per REQ/ACK, ACK held until REQ drops
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus_ack <= 1'b0;
      wait_ff <= 4'h0;
      rx_byte <= 8'h00;
      rx_ph   <= 3'h0;
      rx_cnt  <= 8'h00;
    end else if (!bus_req) begin
      bus_ack <= 1'b0;
      wait_ff <= 4'h0;
    end else if (!bus_ack && wait_ff < ack_dly) begin
      wait_ff <= wait_ff + 4'h1;
    end else if (!bus_ack) begin
      bus_ack <= 1'b1;
      rx_byte <= bus_io ? bus_db_out : tx_byte;
      rx_ph   <= {bus_cd, bus_io, bus_msg};
      rx_cnt  <= rx_cnt + 8'h01;
    end
  end
endmodule // sstm_init_model

// ---- testbench/sstm_target_chk.sv ----
`timescale 1ns/1ps
module sstm_target_chk (
  // Clock and resets
  input wire       mclk,
  input wire       rst,
  input wire       bus_rst,
  // Bus lines
  input wire       bus_ack,
  input wire       bus_req,
  input wire       bus_bsy,
  input wire       bus_cd,
  input wire       bus_io,
  input wire       bus_msg,
  input wire [7:0] bus_db_out,
  input wire       bus_db_oe,
  // Engine side
  input wire       rst_clear
);
  // ****
  // Bus phase checks
  // ****
  default clocking cb @(posedge mclk); endclocking
  // A bus reset may cut any handshake short
  default disable iff (rst || bus_rst);
  sequence s_status; bus_req && bus_cd && bus_io && !bus_msg; endsequence
  sequence s_rst3; bus_rst [*3]; endsequence
  chk_msg_lines: assert property (bus_req && bus_msg |-> bus_cd)
    else $error("message phase without cd");
  chk_msgout_dir: assert property (bus_req && bus_msg && !bus_io |-> !bus_db_oe)
    else $error("message-out with data driven");
  chk_status_byte: assert property (s_status |-> bus_db_oe && (bus_db_out & 8'he5) == 8'h00)
    else $error("status byte reserved bits set");
  chk_bsy_held: assert property (bus_req |-> bus_bsy)
    else $error("req without bsy");
  chk_req_hold: assert property (bus_req && !bus_ack |=> bus_req)
    else $error("req dropped before ack");
  chk_req_setup: assert property ($rose(bus_req) |-> $past({bus_cd, bus_io, bus_msg}, 8) == {bus_cd, bus_io, bus_msg})
    else $error("phase lines not settled before req");
  chk_free_lines: assert property ($fell(bus_bsy) |-> !bus_cd && !bus_io && !bus_msg && !bus_db_oe)
    else $error("lines left driven at bus free");
  chk_bus_reset: assert property (disable iff (rst) s_rst3 |=> !bus_bsy && !bus_req && !bus_db_oe)
    else $error("bus reset did not free the bus");
  chk_rst_clear: assert property (disable iff (rst) s_rst3 ##1 bus_rst |-> ##[0:1] rst_clear)
    else $error("no clear pulse on bus reset");
endmodule // sstm_target_chk

bind sstm_target sstm_target_chk i_chk (.mclk, .rst, .bus_rst, .bus_ack, .bus_req, .bus_bsy, .bus_cd, .bus_io,
  .bus_msg, .bus_db_out, .bus_db_oe, .rst_clear);

// ---- testbench/sstm_target_tb.sv ----
`timescale 1ns/1ps
module sstm_target_tb;
  // ****
  // Bench signals
  // ****
  logic mclk = 1'b0, rst, bus_atn, bus_rst, sel_done, cmd_done, comm_fail, check_condition_flag, stat_busy;
  logic stat_inter, link_cmd, link_flag, parity_enable, data_parity_err, send_save_ptr, want_disconnect, resel_won;
  logic bus_ack, bus_dbp_ok, bus_req, bus_bsy, bus_cd, bus_io, bus_msg, bus_db_oe, disconnect_allowed_bit;
  logic identified, abort_cmd, dev_reset, bus_free_req, resel_req, rst_clear, busy, par_ok;
  logic [7:0] bus_db_in, bus_db_out, tx_byte, rx_byte, rx_cnt;
  logic [3:0] ack_dly;
  logic [2:0] ident_lun, rx_ph;
  logic seen_dr = 0, seen_ab = 0, seen_bf = 0, seen_rc = 0; // Caught pulses
  wire  [5:0] evs = {bus_req, seen_rc, resel_req, seen_bf, seen_ab, seen_dr};
  int num_errors = 0, check_count = 0;
  localparam logic [2:0] PH_ST = 3'b110, PH_MI = 3'b111, PH_MO = 3'b101; // {cd,io,msg}
  initial forever #25 mclk = ~mclk;
  sstm_target i_dut (.mclk, .rst, .bus_ack, .bus_atn, .bus_rst, .bus_db_in, .bus_dbp_ok, .bus_req, .bus_bsy,
    .bus_cd, .bus_io, .bus_msg, .bus_db_out, .bus_db_oe, .sel_done, .cmd_done, .comm_fail, .check_condition_flag,
    .stat_busy, .stat_inter, .link_cmd, .link_flag, .parity_enable, .data_parity_err, .send_save_ptr,
    .want_disconnect, .resel_won, .disconnect_allowed_bit, .identified, .ident_lun, .abort_cmd, .dev_reset,
    .bus_free_req, .resel_req, .rst_clear, .busy);
  sstm_init_model i_init (.mclk, .rst, .bus_req, .bus_cd, .bus_io, .bus_msg, .bus_db_out, .bus_ack, .bus_db_in,
    .bus_dbp_ok, .tx_byte, .par_ok, .ack_dly, .rx_byte, .rx_ph, .rx_cnt);
  // Pulses are one cycle wide, so hold them for the tasks
  always @(posedge mclk) begin
    if (dev_reset) seen_dr <= 1'b1;
    if (abort_cmd) seen_ab <= 1'b1;
    if (bus_free_req) seen_bf <= 1'b1;
    if (rst_clear) seen_rc <= 1'b1;
  end
  // ****
  // Shared tasks
  // ****
  task automatic close_out;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_ev(input int k);
    int i;
    for (i = 0; i < 900 && evs[k] !== 1'b1; i++) @(negedge mclk);
    check_count++;
    if (evs[k] !== 1'b1) begin
      num_errors++;
      $display("BAD event %0d expected 1 seen 0", k);
      close_out;
    end
  endtask
  // Next byte; clr retracts pending requests while ACK is high
  task automatic xfer(input logic [7:0] exp, input logic [2:0] ph, input logic clr);
    logic [7:0] c0;
    int         i;
    c0 = rx_cnt;
    for (i = 0; i < 900 && rx_cnt === c0; i++) @(negedge mclk);
    if (clr) {bus_atn, send_save_ptr, data_parity_err, want_disconnect} = 4'h0;
    for (i = 0; i < 900 && bus_ack; i++) @(negedge mclk);
    if (i == 900 || rx_cnt === c0) begin
      num_errors++;
      $display("BAD byte expected %h seen none", exp);
      close_out;
    end else begin
      chk("byte", rx_byte, exp);
      chk("phase", {5'h00, rx_ph}, {5'h00, ph});
    end
  endtask
  // Reset pulse, then selection with or without attention
  task automatic start(input logic atn);
    rst = 1'b1;
    // Attention stands before and through selection
    {bus_atn, bus_rst, sel_done, cmd_done, comm_fail, check_condition_flag, stat_busy, stat_inter} = {atn, 7'h00};
    {link_cmd, link_flag, parity_enable, data_parity_err, send_save_ptr, want_disconnect, resel_won} = '0;
    {par_ok, ack_dly, tx_byte} = {1'b1, 4'h0, 8'h00};
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    {seen_dr, seen_ab, seen_bf, seen_rc} = 4'h0;
    // Two edges for attention to pass the synchroniser
    repeat (2) @(negedge mclk);
    sel_done = 1'b1;
    @(negedge mclk);
    sel_done = 1'b0;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_status;
    logic [5:0] cs [4] = '{6'b000000, 6'b101100, 6'b010001, 6'b111110};
    logic [5:0] v;
    for (int i = 0; i < 4; i++) begin
      v = cs[i];
      start(1'b0);
      ack_dly = 4'(i * 5);
      {check_condition_flag, stat_busy, stat_inter, link_cmd, link_flag, comm_fail} = v;
      cmd_done = !v[0];
      xfer({3'h0, v[3], v[4], 1'b0, v[5], 1'b0}, PH_ST, 1'b0);
      xfer(v[2] ? (v[1] ? 8'h0b : 8'h0a) : 8'h00, PH_MI, 1'b0);
      wait_ev(2);
      repeat (30) @(negedge mclk);
      chk("count", rx_cnt, 8'h02);
      chk("busy", {7'h00, busy}, 8'h00);
    end
  endtask
  task automatic t_reject;
    logic [7:0] bad [3] = '{8'h01, 8'h43, 8'h05};
    for (int i = 0; i < 3; i++) begin
      start(1'b1);
      tx_byte = bad[i];
      xfer(bad[i], PH_MO, 1'b1);
      tx_byte = 8'h08;
      xfer(8'h07, PH_MI, 1'b0);
      xfer(8'h08, PH_MO, 1'b0);
    end
  endtask
  task automatic t_imsg;
    for (int k = 0; k < 2; k++) begin
      start(1'b1);
      tx_byte = k ? 8'h06 : 8'h0c;
      xfer(tx_byte, PH_MO, 1'b1);
      wait_ev(k);
      chk("drop", {5'h00, bus_bsy, bus_msg, busy}, 8'h00);
    end
    start(1'b1);
    {parity_enable, par_ok, tx_byte} = {2'b10, 8'h08};
    for (int k = 0; k < 3; k++) xfer(8'h08, PH_MO, 1'b0);
    wait_ev(1);
    chk("drop", {5'h00, bus_bsy, bus_msg, busy}, 8'h00);
  endtask
  task automatic t_discon(input logic [7:0] idb);
    start(1'b1);
    {ack_dly, tx_byte} = {4'h9, idb};
    xfer(idb, PH_MO, 1'b1);
    repeat (4) @(negedge mclk);
    chk("ident", {identified, disconnect_allowed_bit, 3'h0, ident_lun}, {1'b1, idb[6], 3'h0, idb[2:0]});
    if (idb[6]) begin
      send_save_ptr = 1'b1;
      xfer(8'h02, PH_MI, 1'b1);
      data_parity_err = 1'b1;
      xfer(8'h03, PH_MI, 1'b1);
      want_disconnect = 1'b1;
      xfer(8'h04, PH_MI, 1'b1);
      wait_ev(2);
      chk("bsy", {7'h00, bus_bsy}, 8'h00);
      cmd_done = 1'b1;
      wait_ev(3);
      resel_won = 1'b1;
      @(negedge mclk);
      resel_won = 1'b0;
    end else begin
      {want_disconnect, cmd_done} = 2'b11;
    end
    xfer(8'h00, PH_ST, 1'b0);
    xfer(8'h00, PH_MI, 1'b0);
  endtask
  task automatic t_busrst;
    start(1'b0);
    {ack_dly, cmd_done} = {4'hf, 1'b1};
    wait_ev(5);
    bus_rst = 1'b1;
    repeat (6) @(negedge mclk);
    wait_ev(4);
    chk("lines", {4'h0, bus_req, bus_bsy, bus_db_oe, busy}, 8'h00);
    bus_rst = 1'b0;
  endtask
  initial begin
    t_status;
    t_reject;
    t_imsg;
    t_discon(8'hc2);
    t_discon(8'h83);
    t_busrst;
    close_out;
  end
endmodule // sstm_target_tb
